/* File: rtl/odm_device.sv */
// Overview of operation
// - bit 47 read, 46 space, 45 burst
// - array access begins after bits 47..16
// - strobe level during command picks latency multiple
// - read data follows latency with toggling strobe
// - upper byte on strobe high, lower on low
// - whole words, address advances after each word except in register reads
// - strobe held low pauses between read words
// - read bursts wrap or run linear, roll over
// - bus clock need not run freely
// - register reads repeat upper then lower byte
// - bit 47 low means write, 46 space
// - write bytes captured rising then falling edge
// - strobe high masks write byte, low stores
// - no extra latency inside write data
// - write bursts: legacy wrap, hybrid, linear
// - linear write rolls over past last address
// - zero-latency writes store full words unmasked
// - each address one 16-bit word, 32 bits
// - device drives strobe throughout read transactions
// - three command words over first six edges
// - bit 45 low wrapped, high linear
// - mem write: strobe released after command phase
`timescale 1ns/100ps
`default_nettype none
`include "odm_params.svh"
module odm_device import odm_pkg::*; #(
    parameter int ADDR_BITS = 32,
    parameter int LAT_W = 4
) (
    input wire logic clock_in,
    input wire logic resetn_in,
    input wire logic chip_select_n_in,
    input wire logic bus_clock_true_in,
    input wire logic bus_clock_complement_in,
    input wire logic [7:0] dq_in,
    output logic [7:0] dq_out,
    output logic dq_oe_n_out,
    input wire logic read_write_data_strobe_in,
    output logic read_write_data_strobe_out,
    output logic read_write_data_strobe_oe_n_out,
    input wire logic extra_latency_in,
    input wire logic [LAT_W-1:0] latency_count_in,
    input wire logic [1:0] burst_len_sel_in,
    input wire logic hybrid_wrap_in,
    output logic array_req_valid_out,
    input wire logic array_req_ready_in,
    output logic array_req_write_out,
    output logic array_req_reg_out,
    output logic [1:0] array_req_keep_out,
    output logic [31:0] array_req_addr_out,
    output logic [15:0] array_req_wdata_out,
    input wire logic array_rdata_valid_in,
    input wire logic [15:0] array_rdata_in,
    output logic row_access_start_out,
    output logic write_overrun_out
);
    localparam logic [31:0] AMASK = 32'((64'h1 << ADDR_BITS) - 64'h1);
    localparam int REQ_W = 52;

    if (ADDR_BITS < 1 || ADDR_BITS > 32 || LAT_W < 1 || LAT_W > 8) begin : g_chk
        $error("odm_device: address width 1..32, latency width 1..8");
    end

    logic [1:0] rst_q;
    logic rst_n;
    logic [11:0] sync1_q;
    logic [11:0] sync2_q;
    logic cs_s, ck_s, ckc_s, ds_s, ck_prev_q, rise, fall, edge_any;
    logic [7:0] dq_s;
    odm_state_e st_q;
    logic [2:0] edge_cnt_q;
    logic [47:0] ca_q;
    logic [47:0] ca_next;
    logic ext_q;
    logic [LAT_W:0] lat_q;
    logic [LAT_W:0] lat_load;
    logic [31:0] addr_q, start_q, wm, nx;
    logic hyb_q, lin_eff;
    logic [15:0] rd_word_q;
    logic rd_word_v_q, rd_pend_q, stale_q, phase_hi_q;
    logic [7:0] wbyte_q;
    logic wkeep_hi_q;
    logic rd_push, wr_push, rd_adv, buf_ready;
    logic [1:0] wr_keep;
    logic [REQ_W-1:0] req_data;

    function automatic logic [31:0] odm_word_addr(input logic [47:0] ca);
        odm_word_addr = {ca[`ODM_ROWCOL_HI:`ODM_ROWCOL_LO], ca[`ODM_LOWCOL_HI:0]} & AMASK;
    endfunction : odm_word_addr

    function automatic logic [31:0] odm_next_addr(input logic [31:0] a, input logic lin, input logic [31:0] m);
        logic [31:0] inc;
        inc = a + 32'h1;
        odm_next_addr = lin ? (inc & AMASK) : ((a & ~m) | (inc & m));
    endfunction : odm_next_addr

    always_ff @(posedge clock_in or negedge resetn_in) begin
        if (!resetn_in) begin
            rst_q <= `ODM_RST_INIT;
        end else begin
            rst_q <= {rst_q[0], 1'b1};
        end
    end
    assign rst_n = rst_q[1];

    // two-stage synchroniser for every bus pin: select, both bus clocks, strobe and data
    always_ff @(posedge clock_in or negedge rst_n) begin
        if (!rst_n) begin
            sync1_q <= `ODM_SYNC_INIT;
            sync2_q <= `ODM_SYNC_INIT;
            ck_prev_q <= 1'b0;
        end else begin
            sync1_q <= {chip_select_n_in, bus_clock_true_in, bus_clock_complement_in,
                        read_write_data_strobe_in, dq_in};
            sync2_q <= sync1_q;
            ck_prev_q <= ck_s;
        end
    end
    assign cs_s = sync2_q[`ODM_SY_CS];
    assign ck_s = sync2_q[`ODM_SY_CK];
    assign ckc_s = sync2_q[`ODM_SY_CKC];
    assign ds_s = sync2_q[`ODM_SY_DS];
    assign dq_s = sync2_q[7:0];
    // only edges move the logic, so a stopped bus clock just stalls it
    assign rise = ck_s && !ck_prev_q;
    assign fall = !ck_s && ck_prev_q;
    assign edge_any = rise || fall;
    assign ca_next = {ca_q[39:0], dq_s};
    assign lat_load = ext_q ? {latency_count_in, 1'b0} : {1'b0, latency_count_in};
    assign wm = 32'((`ODM_WRAP_MIN_WORDS << burst_len_sel_in) - 32'h1);
    assign lin_eff = ca_q[`ODM_BT_BIT] || hyb_q;
    assign nx = odm_next_addr(addr_q, lin_eff, wm);

    // transaction sequencing
    always_ff @(posedge clock_in or negedge rst_n) begin
        if (!rst_n) begin
            st_q <= ODM_IDLE;
        end else if (cs_s && st_q != ODM_IDLE) begin
            st_q <= ODM_IDLE;
        end else begin
            unique case (st_q)
                ODM_IDLE: begin
                    if (!cs_s) begin
                        st_q <= (!ck_s && ckc_s) ? ODM_CMD : ODM_HOLD;
                    end
                end
                ODM_CMD: begin
                    if (edge_any && edge_cnt_q == `ODM_CA_LAST) begin
                        if (!ca_next[`ODM_RW_BIT] && ca_next[`ODM_AS_BIT]) begin
                            st_q <= ODM_WDATA;
                        end else if (lat_load == '0) begin
                            st_q <= ca_next[`ODM_RW_BIT] ? ODM_RDATA : ODM_WDATA;
                        end else begin
                            st_q <= ODM_LAT;
                        end
                    end
                end
                ODM_LAT: begin
                    if (fall && lat_q == {{LAT_W{1'b0}}, 1'b1}) begin
                        st_q <= ca_q[`ODM_RW_BIT] ? ODM_RDATA : ODM_WDATA;
                    end
                end
                ODM_RDATA, ODM_WDATA, ODM_HOLD: begin
                    st_q <= st_q;
                end
            endcase
        end
    end

    // command capture and latency count
    always_ff @(posedge clock_in or negedge rst_n) begin
        if (!rst_n) begin
            edge_cnt_q <= '0;
            ca_q <= '0;
            ext_q <= 1'b0;
            lat_q <= '0;
            row_access_start_out <= 1'b0;
        end else begin
            row_access_start_out <= 1'b0;
            if (st_q == ODM_IDLE) begin
                edge_cnt_q <= '0;
                ext_q <= extra_latency_in;
            end else if (st_q == ODM_CMD && edge_any) begin
                ca_q <= ca_next;
                edge_cnt_q <= edge_cnt_q + 3'h1;
                row_access_start_out <= (edge_cnt_q == `ODM_CA_ROWCOL);
                if (edge_cnt_q == `ODM_CA_LAST) begin
                    lat_q <= lat_load;
                end
            end else if (st_q == ODM_LAT && fall) begin
                lat_q <= lat_q - 1'b1;
            end
        end
    end

    // word address: wrap, hybrid wrap, linear with rollover
    assign rd_adv = st_q == ODM_RDATA && fall && phase_hi_q && !ca_q[`ODM_AS_BIT];
    always_ff @(posedge clock_in or negedge rst_n) begin
        if (!rst_n) begin
            addr_q <= '0;
            start_q <= '0;
            hyb_q <= 1'b0;
        end else if (st_q == ODM_CMD && edge_any && edge_cnt_q == `ODM_CA_LAST) begin
            addr_q <= odm_word_addr(ca_next);
            start_q <= odm_word_addr(ca_next);
            hyb_q <= 1'b0;
        end else if (rd_adv || wr_push) begin
            if (!lin_eff && hybrid_wrap_in && nx == start_q) begin
                addr_q <= ((start_q & ~wm) + wm + 32'h1) & AMASK;
                hyb_q <= 1'b1;
            end else begin
                addr_q <= nx;
            end
        end
    end

    // read word fetch: one request outstanding, stale answers dropped
    assign rd_push = (st_q == ODM_LAT || st_q == ODM_RDATA) && ca_q[`ODM_RW_BIT] && !rd_word_v_q
        && !rd_pend_q && !stale_q && buf_ready;
    always_ff @(posedge clock_in or negedge rst_n) begin
        if (!rst_n) begin
            rd_word_q <= '0;
            rd_word_v_q <= 1'b0;
            rd_pend_q <= 1'b0;
            stale_q <= 1'b0;
            phase_hi_q <= 1'b0;
        end else if (cs_s) begin
            rd_word_v_q <= 1'b0;
            phase_hi_q <= 1'b0;
            rd_pend_q <= rd_pend_q && !array_rdata_valid_in;
            stale_q <= rd_pend_q && !array_rdata_valid_in;
        end else begin
            if (rd_push) begin
                rd_pend_q <= 1'b1;
            end else if (array_rdata_valid_in && rd_pend_q) begin
                rd_pend_q <= 1'b0;
                if (stale_q) begin
                    stale_q <= 1'b0;
                end else begin
                    rd_word_q <= array_rdata_in;
                    rd_word_v_q <= 1'b1;
                end
            end
            if (st_q == ODM_RDATA && rise && rd_word_v_q) begin
                phase_hi_q <= 1'b1;
            end else if (st_q == ODM_RDATA && fall && phase_hi_q) begin
                phase_hi_q <= 1'b0;
                rd_word_v_q <= 1'b0;
            end
        end
    end

    // write capture: first byte on rise, second on fall, strobe as keep mask
    assign wr_push = st_q == ODM_WDATA && fall && !cs_s;
    assign wr_keep = ca_q[`ODM_AS_BIT] ? 2'b00 : {wkeep_hi_q, ds_s};
    always_ff @(posedge clock_in or negedge rst_n) begin
        if (!rst_n) begin
            wbyte_q <= '0;
            wkeep_hi_q <= 1'b0;
            write_overrun_out <= 1'b0;
        end else begin
            if (st_q == ODM_WDATA && rise) begin
                wbyte_q <= dq_s;
                wkeep_hi_q <= ds_s;
            end
            // the host cannot be stalled mid-write, so a full buffer is only flagged
            if (wr_push && !buf_ready) begin
                write_overrun_out <= 1'b1;
            end else if (st_q == ODM_IDLE && !cs_s) begin
                write_overrun_out <= 1'b0;
            end
        end
    end

    assign req_data = wr_push ? {1'b1, ca_q[`ODM_AS_BIT], wr_keep, addr_q, wbyte_q, dq_s}
        : {1'b0, ca_q[`ODM_AS_BIT], 2'b00, addr_q, 16'h0000};

    odm_buf #(.W(REQ_W), .DEPTH(2)) u_buf (
        .clock_in(clock_in),
        .rst_n_in(rst_n),
        .in_valid_in(rd_push || wr_push),
        .in_ready_out(buf_ready),
        .in_data_in(req_data),
        .out_valid_out(array_req_valid_out),
        .out_ready_in(array_req_ready_in),
        .out_data_out({array_req_write_out, array_req_reg_out, array_req_keep_out,
                       array_req_addr_out, array_req_wdata_out})
    );

    // pin drivers
    always_ff @(posedge clock_in or negedge rst_n) begin
        if (!rst_n) begin
            dq_out <= '0;
            dq_oe_n_out <= 1'b1;
            read_write_data_strobe_out <= 1'b0;
            read_write_data_strobe_oe_n_out <= 1'b1;
        end else if (cs_s || st_q == ODM_HOLD) begin
            dq_oe_n_out <= 1'b1;
            read_write_data_strobe_oe_n_out <= 1'b1;
            read_write_data_strobe_out <= 1'b0;
        end else if (st_q == ODM_IDLE) begin
            read_write_data_strobe_out <= extra_latency_in;
            read_write_data_strobe_oe_n_out <= !(!ck_s && ckc_s);
        end else if (st_q == ODM_CMD && edge_any && edge_cnt_q == `ODM_CA_LAST) begin
            read_write_data_strobe_out <= 1'b0;
            read_write_data_strobe_oe_n_out <= !(ca_next[`ODM_RW_BIT] || ca_next[`ODM_AS_BIT]);
            dq_oe_n_out <= !ca_next[`ODM_RW_BIT];
        end else if (st_q == ODM_LAT && ca_q[`ODM_RW_BIT]) begin
            read_write_data_strobe_oe_n_out <= 1'b0;
            dq_oe_n_out <= 1'b0;
        end else if (st_q == ODM_RDATA) begin
            if (rise && rd_word_v_q) begin
                dq_out <= rd_word_q[15:8];
                read_write_data_strobe_out <= 1'b1;
            end else if (fall && phase_hi_q) begin
                dq_out <= rd_word_q[7:0];
                read_write_data_strobe_out <= 1'b0;
            end else if (rise) begin
                read_write_data_strobe_out <= 1'b0;
            end
        end
    end

    default clocking cb @(posedge clock_in); endclocking
    default disable iff (!rst_n);

    AST_START_IDLE_CLK: assert property ($rose(st_q == ODM_CMD) |-> $past(!ck_s && ckc_s && !cs_s))
        else $error("transaction started with bus clock not idle");
    AST_READ_DECODE: assert property (st_q == ODM_RDATA |-> ca_q[`ODM_RW_BIT])
        else $error("read data phase without read command");
    AST_WRITE_DECODE: assert property (st_q == ODM_WDATA |-> !ca_q[`ODM_RW_BIT])
        else $error("write data phase without write command");
    AST_ROW_ACCESS: assert property ((st_q == ODM_CMD && edge_any && edge_cnt_q == `ODM_CA_ROWCOL)
        |=> row_access_start_out ##1 !row_access_start_out)
        else $error("array access start not pulsed after row bits");
    AST_LAT_DOUBLE: assert property ((st_q == ODM_CMD && edge_any && edge_cnt_q == `ODM_CA_LAST && ext_q)
        |=> lat_q == {$past(latency_count_in), 1'b0})
        else $error("extra latency not doubled");
    AST_HI_BYTE_FIRST: assert property ((st_q == ODM_RDATA && rise && rd_word_v_q && !cs_s)
        |=> read_write_data_strobe_out && dq_out == $past(rd_word_q[15:8]))
        else $error("upper byte not on strobe high");
    AST_PAUSE_LOW: assert property ((st_q == ODM_RDATA && rise && !rd_word_v_q && !cs_s)
        |=> !read_write_data_strobe_out)
        else $error("strobe not held low during pause");
    AST_LINEAR_STEP: assert property ((wr_push && ca_q[`ODM_BT_BIT])
        |=> addr_q == (($past(addr_q) + 32'h1) & AMASK))
        else $error("linear write address did not step");
    AST_REG_REPEAT: assert property ((st_q == ODM_RDATA && ca_q[`ODM_AS_BIT]) |=> $stable(addr_q))
        else $error("register read address moved");
    AST_READ_DRIVES_DS: assert property ((st_q == ODM_RDATA && !cs_s) |-> !read_write_data_strobe_oe_n_out)
        else $error("strobe not driven in read data");
    AST_TERMINATE: assert property ((cs_s && st_q != ODM_IDLE) |=> st_q == ODM_IDLE ##1 dq_oe_n_out)
        else $error("select high did not end transaction");

    COV_READ_EXT: cover property (ext_q && st_q == ODM_LAT ##[1:300] st_q == ODM_RDATA);
    COV_MASKED_WRITE: cover property (wr_push && wr_keep != 2'b00);
    COV_REG_WRITE: cover property (wr_push && ca_q[`ODM_AS_BIT]);
    COV_HYBRID: cover property ($rose(hyb_q));
endmodule : odm_device
`default_nettype wire

/* File: rtl/odm_params.svh */
`ifndef ODM_PARAMS_SVH
`define ODM_PARAMS_SVH
`define ODM_RST_INIT 2'b00
`define ODM_SYNC_INIT 12'ha00
`define ODM_SY_CS 11
`define ODM_SY_CK 10
`define ODM_SY_CKC 9
`define ODM_SY_DS 8
`define ODM_CA_LAST 3'h5
`define ODM_CA_ROWCOL 3'h3
`define ODM_RW_BIT 47
`define ODM_AS_BIT 46
`define ODM_BT_BIT 45
`define ODM_ROWCOL_HI 44
`define ODM_ROWCOL_LO 16
`define ODM_LOWCOL_HI 2
`define ODM_WRAP_MIN_WORDS 32'h10
`endif

/* File: rtl/odm_pkg.sv */
package odm_pkg;
    typedef enum logic [2:0] {ODM_IDLE, ODM_CMD, ODM_LAT, ODM_RDATA, ODM_WDATA, ODM_HOLD} odm_state_e;
endpackage : odm_pkg

/* File: rtl/odm_buf.sv */
`timescale 1ns/100ps
`default_nettype none
module odm_buf #(
    parameter int W = 52,
    parameter int DEPTH = 2
) (
    input wire logic clock_in,
    input wire logic rst_n_in,
    input wire logic in_valid_in,
    output logic in_ready_out,
    input wire logic [W-1:0] in_data_in,
    output logic out_valid_out,
    input wire logic out_ready_in,
    output logic [W-1:0] out_data_out
);
    logic [W-1:0] spare_q;
    logic spare_v_q;

    if (DEPTH != 2) begin : g_chk
        $error("odm_buf holds exactly two entries");
    end

    // output stage plus one spare entry; ready drops only when both are full
    always_ff @(posedge clock_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            out_valid_out <= 1'b0;
            out_data_out <= '0;
            spare_q <= '0;
            spare_v_q <= 1'b0;
            in_ready_out <= 1'b0;
        end else begin
            logic ov;
            logic sv;
            ov = out_valid_out;
            sv = spare_v_q;
            if (out_ready_in && ov) begin
                if (sv) begin
                    out_data_out <= spare_q;
                    sv = 1'b0;
                end else begin
                    ov = 1'b0;
                end
            end
            if (in_valid_in && in_ready_out) begin
                if (!ov) begin
                    out_data_out <= in_data_in;
                    ov = 1'b1;
                end else begin
                    spare_q <= in_data_in;
                    sv = 1'b1;
                end
            end
            out_valid_out <= ov;
            spare_v_q <= sv;
            in_ready_out <= !sv;
        end
    end
endmodule : odm_buf
`default_nettype wire

/* File: verif/odm_host.sv */
`timescale 1ns/100ps
`default_nettype none
module odm_host (
    input wire logic clock_in,
    input wire logic [7:0] ddq_in,
    input wire logic ddq_oe_n_in,
    input wire logic dds_in,
    input wire logic dds_oe_n_in,
    output logic cs_n_out,
    output logic ck_out,
    output logic ckc_out,
    output logic [7:0] dq_out,
    output logic ds_out
);
    logic cs_q = 1'b1;
    logic ck_q = 1'b0;
    logic [7:0] dq_q = 8'h00;
    logic [7:0] wdq_q = 8'h00;
    logic [7:0] hi_q = 8'h00;
    logic ds_q = 1'b0, wds_q = 1'b0, dq_en_q = 1'b0, ds_en_q = 1'b0;
    logic rd_q = 1'b0, prev_q = 1'b0, hi_ok_q = 1'b0, rel_err_q = 1'b0;
    logic [15:0] words[$];
    assign cs_n_out = cs_q;
    assign ck_out = ck_q;
    assign ckc_out = ~ck_q;
    assign dq_out = wdq_q;
    assign ds_out = wds_q;
    // a line nobody drives toggles every cycle
    always @(posedge clock_in) begin
        wdq_q <= !ddq_oe_n_in ? ddq_in : (dq_en_q ? dq_q : ~wdq_q);
        wds_q <= !dds_oe_n_in ? dds_in : (ds_en_q ? ds_q : ~wds_q);
        prev_q <= dds_in;
        if (rd_q && !dds_oe_n_in && dds_in && !prev_q) hi_q <= ddq_in;
        if (rd_q && !dds_oe_n_in && dds_in && !prev_q) hi_ok_q <= 1'b1;
        if (rd_q && !dds_oe_n_in && !dds_in && prev_q && hi_ok_q) words.push_back({hi_q, ddq_in});
        if (rd_q && dds_oe_n_in) rel_err_q <= 1'b1;
    end
    // one bus clock edge, data centred between edges
    task automatic step(input logic [7:0] d, input logic m);
        dq_q <= d;
        ds_q <= m;
        repeat (2) @(posedge clock_in);
        ck_q <= ~ck_q;
        repeat (2) @(posedge clock_in);
    endtask : step
    task automatic xfer(input logic [47:0] ca, input int lat, input int nw, input logic [15:0] wd,
                        input logic [1:0] m0, input int stop);
        int k, i;
        logic wr, zl;
        wr = !ca[47];
        zl = wr && ca[46];
        k = 1;
        hi_ok_q <= 1'b0;
        cs_q <= 1'b0;
        dq_en_q <= 1'b1;
        repeat (4) @(posedge clock_in);
        for (i = 0; i < 6; i++) begin
            step(ca[47 - 8 * i -: 8], 1'b0);
            if (!dds_oe_n_in && dds_in) k = 2;
        end
        rd_q <= !wr;
        dq_en_q <= wr;
        ds_en_q <= wr && !zl;
        if (!zl) repeat (2 * lat * k) step(8'h00, 1'b0);
        for (i = 0; wr && i < nw; i++) begin
            step(wd[15:8] + 8'(i), i == 0 && m0[1]);
            step(wd[7:0] + 8'(i), i == 0 && m0[0]);
        end
        for (i = 0; !wr && i < 300 && words.size() < nw && i != stop; i++) begin
            step(8'h00, 1'b0);
            step(8'h00, 1'b0);
        end
        repeat (6) @(posedge clock_in);
        rd_q <= 1'b0;
        dq_en_q <= 1'b0;
        ds_en_q <= 1'b0;
        cs_q <= 1'b1;
        repeat (8) @(posedge clock_in);
    endtask : xfer
endmodule : odm_host
`default_nettype wire

/* File: verif/tb_top.sv */
`timescale 1ns/100ps
`default_nettype none
module tb_top;
    typedef struct {logic rd; logic rg; logic lin; logic [31:0] a; int nw;
                    logic ex; logic [3:0] lat; int dly; logic hyb; logic [1:0] m0;} odm_row_s;
    localparam logic [15:0] REGV = 16'hc35a;
    logic clock_in = 1'b0;
    logic resetn_in = 1'b0;
    logic ex = 1'b0, hyb = 1'b0, ready = 1'b1, rv = 1'b0, pend = 1'b0, prg = 1'b0;
    logic [3:0] lat = 4'h1;
    logic [15:0] rdata = 16'h0000;
    logic [31:0] paddr = 32'h0;
    logic cs_n, ck, ckc, ds_in, dq_oe_n, ds_o, ds_oe_n, req_v, req_w, req_r, row_st, ovr;
    logic [7:0] dq_in, dq_o;
    logic [1:0] keep;
    logic [31:0] addr;
    logic [15:0] wdata;
    logic [50:0] wlog[$];
    int dly = 1, cnt = 0, n_fail = 0, n_tests = 0, n_row = 0, cyc = 0, i;
    odm_row_s r;
    odm_row_s rows[9] = '{
        '{1, 0, 1, 32'h100, 3, 0, 4'h2, 1, 0, 2'b00},
        '{1, 0, 0, 32'h20e, 4, 1, 4'h1, 2, 0, 2'b00},
        '{1, 0, 0, 32'h20e, 18, 0, 4'h1, 1, 1, 2'b00},
        '{1, 0, 1, 32'hffe, 3, 0, 4'h1, 12, 0, 2'b00},
        '{1, 1, 0, 32'h001, 2, 0, 4'h1, 1, 0, 2'b00},
        '{0, 0, 1, 32'hffe, 3, 1, 4'h2, 1, 0, 2'b10},
        '{0, 0, 0, 32'h31e, 3, 0, 4'h1, 1, 0, 2'b01},
        '{0, 0, 0, 32'h30e, 18, 0, 4'h1, 1, 1, 2'b00},
        '{0, 1, 1, 32'h001, 1, 0, 4'h1, 1, 0, 2'b11}
    };
    odm_device #(.ADDR_BITS(12), .LAT_W(4)) uut (
        .clock_in(clock_in), .resetn_in(resetn_in), .chip_select_n_in(cs_n),
        .bus_clock_true_in(ck), .bus_clock_complement_in(ckc), .dq_in(dq_in), .dq_out(dq_o),
        .dq_oe_n_out(dq_oe_n), .read_write_data_strobe_in(ds_in), .read_write_data_strobe_out(ds_o),
        .read_write_data_strobe_oe_n_out(ds_oe_n), .extra_latency_in(ex), .latency_count_in(lat),
        .burst_len_sel_in(2'b00), .hybrid_wrap_in(hyb), .array_req_valid_out(req_v),
        .array_req_ready_in(ready), .array_req_write_out(req_w), .array_req_reg_out(req_r),
        .array_req_keep_out(keep), .array_req_addr_out(addr), .array_req_wdata_out(wdata),
        .array_rdata_valid_in(rv), .array_rdata_in(rdata), .row_access_start_out(row_st),
        .write_overrun_out(ovr));
    odm_host host (.clock_in(clock_in), .ddq_in(dq_o), .ddq_oe_n_in(dq_oe_n), .dds_in(ds_o),
        .dds_oe_n_in(ds_oe_n), .cs_n_out(cs_n), .ck_out(ck), .ckc_out(ckc), .dq_out(dq_in), .ds_out(ds_in));
    function automatic logic [15:0] memf(input logic [31:0] a);
        return a[15:0] ^ 16'h5a3c;
    endfunction : memf
    // word address of the i-th word of a burst, wrap length 16
    function automatic logic [31:0] exp_addr(input odm_row_s r, input int i);
        logic [31:0] base;
        base = r.a & 32'hfffffff0;
        if (r.rg) return r.a;
        if (r.lin) return (r.a + i) & 32'hfff;
        if (r.hyb && i >= 16) return base + 32'h10 + i - 16;
        return base + ((r.a - base + i) % 16);
    endfunction : exp_addr
    task automatic check(input logic [63:0] seen, input logic [63:0] exp, input string msg);
        n_tests++;
        if (seen !== exp) begin
            n_fail++;
            $display("ERROR %0t %s seen %h expected %h", $time, msg, seen, exp);
        end
    endtask : check
    task automatic conclude;
        $display("tests %0d failures %0d", n_tests, n_fail);
        if (n_fail == 0 && n_tests > 0) $display("RESULT: PASS");
        else $display("RESULT: FAIL");
        $finish;
    endtask : conclude
    always #2 clock_in = ~clock_in;
    // array side: logs writes, answers reads dly+1 cycles after the request
    always @(posedge clock_in) begin
        cyc <= cyc + 1;
        rv <= 1'b0;
        if (row_st) n_row <= n_row + 1;
        if (req_v && ready && req_w) wlog.push_back({req_r, keep, addr, wdata});
        if (req_v && ready && !req_w) begin
            pend <= 1'b1;
            prg <= req_r;
            paddr <= addr;
            cnt <= dly;
        end else if (pend && cnt > 0) begin
            cnt <= cnt - 1;
        end else if (pend) begin
            pend <= 1'b0;
            rv <= 1'b1;
            rdata <= prg ? REGV : memf(paddr);
        end
        if (cyc == 20000) begin
            n_fail++;
            conclude();
        end
    end
    initial begin
        repeat (4) @(posedge clock_in);
        resetn_in <= 1'b1;
        repeat (6) @(posedge clock_in);
        check({dq_oe_n, ds_oe_n, req_v, ovr}, 4'b1100, "reset outputs");
        foreach (rows[j]) begin
            r = rows[j];
            ex <= r.ex;
            lat <= r.lat;
            hyb <= r.hyb;
            dly <= r.dly;
            host.words.delete();
            wlog.delete();
            @(posedge clock_in);
            host.xfer({r.rd, r.rg, r.lin, r.a[31:3], 13'h0, r.a[2:0]}, r.lat, r.nw, 16'h1280, r.m0, -1);
            for (i = 0; r.rd && i < r.nw; i++) check(host.words[i], r.rg ? REGV : memf(exp_addr(r, i)), "rd");
            for (i = 0; !r.rd && i < r.nw; i++) check(wlog[i], {r.rg, (i == 0 && !r.rg) ? r.m0 : 2'b00,
                exp_addr(r, i), 16'(16'h1280 + i * 16'h0101)}, "wr");
            if (!r.rd) check(wlog.size(), r.nw, "write count");
        end
        check(n_row, 9, "row starts");
        check(host.rel_err_q, 1'b0, "strobe released in read");
        ready <= 1'b0;
        wlog.delete();
        host.xfer({3'b001, 29'h20, 16'h0}, 1, 5, 16'h1280, 2'b00, -1);
        check(ovr, 1'b1, "overrun flag");
        ready <= 1'b1;
        repeat (8) @(posedge clock_in);
        check(wlog.size(), 2, "buffer depth");
        check(wlog[1], {3'b000, 32'h101, 16'h1381}, "kept word");
        resetn_in <= 1'b0;
        repeat (2) @(posedge clock_in);
        check({dq_oe_n, ds_oe_n, req_v, ovr}, 4'b1100, "mid reset");
        resetn_in <= 1'b1;
        repeat (6) @(posedge clock_in);
        dly <= 45;
        host.words.delete();
        host.xfer({3'b101, 29'h40, 16'h0}, 1, 8, 16'h0, 2'b00, 2);
        dly <= 1;
        host.words.delete();
        host.xfer({3'b101, 29'h10, 16'h5}, 1, 2, 16'h0, 2'b00, -1);
        check(host.words[0], memf(32'h85), "after abort");
        check(host.words[1], memf(32'h86), "after abort");
        wlog.delete();
        host.ck_q <= 1'b1;
        @(posedge clock_in);
        host.xfer({3'b001, 29'h30, 16'h0}, 1, 2, 16'h1280, 2'b00, -1);
        host.ck_q <= 1'b0;
        repeat (8) @(posedge clock_in);
        check(wlog.size(), 0, "refused start");
        conclude();
    end
endmodule : tb_top
`default_nettype wire
